// >>> common/gpio_defines.vh
// constants for the digital general-purpose pin block
`ifndef GPIO_DEFINES_VH
`define GPIO_DEFINES_VH

`define GPIO_PINS         24
`define GPIO_PIN_BITS     5
`define TX_CHANNELS       8
`define SRC_COUNT         32
`define SRC_BITS          5

// register word addresses (byte address bits [7:2])
`define REG_PIN_DIR       6'h00
`define REG_RISE_EN       6'h01
`define REG_FALL_EN       6'h02
`define REG_PIN_LEVEL     6'h03
`define REG_STREAM_STATUS 6'h04
`define REG_TX_MODE       6'h05
`define REG_TX_PIN_LO     6'h06
`define REG_TX_PIN_HI     6'h07
`define REG_ATTEN_CMD     6'h08
`define REG_ATTEN_STATE   6'h09
`define REG_ATTEN_PEND    6'h0A
`define REG_MAP_MASK      6'h0B
`define REG_MAP_VALUE     6'h0C
`define REG_OUT_SEL_BASE  6'h10

// tx_mode field codes, two bits per channel
`define MODE_DIRECT       2'h0
`define MODE_LATCH        2'h1
`define MODE_TWO_STATE    2'h2

// attenuation command fields
`define CMD_CH_LSB        16
`define CMD_SLOT_BIT      20
`define ATTEN_BITS        10

`define AXI_OKAY          2'h0
`define AXI_SLVERR        2'h2

`endif

// >>> verilog/pin_edge_sync.v
// two-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module pin_edge_sync #(
    parameter WIDTH = 24
) (
    // clock and reset
    input  wire             aclk,
    input  wire             aresetn,
    input  wire             clk_en,
    // pins and results
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] level,
    output reg  [WIDTH-1:0] rise_pulse,
    output reg  [WIDTH-1:0] fall_pulse
);

reg [WIDTH-1:0] meta;
reg [WIDTH-1:0] sync;

// first stage feeds only the second; edges compare sync against last level
always @(posedge aclk) begin
    if (!aresetn) begin
        meta       <= {WIDTH{1'b0}};
        sync       <= {WIDTH{1'b0}};
        level      <= {WIDTH{1'b0}};
        rise_pulse <= {WIDTH{1'b0}};
        fall_pulse <= {WIDTH{1'b0}};
    end else if (clk_en) begin
        meta       <= pin_in;
        sync       <= meta;
        level      <= sync;
        rise_pulse <= sync & ~level;
        fall_pulse <= ~sync & level;
    end
end

endmodule

// >>> verilog/gpio_trigger_mux.v
// digital pin block: stream triggers, tx attenuation latch/two-state, control-out mux
// Functional notes
// - twenty-four pins, each input or output
// - separate streams on rising and falling edges
// - input functions assignable to pins 0..23
// - latch mode holds attenuation until pin rises
// - one latch pin releases many channels
// - two-state mode picks stored setting by level
// - many channels share one select pin
// - control-out mux routes any signal anywhere
// - mapping pins forwarded to embedded processor
`timescale 1ns/1ps
`include "gpio_defines.vh"
module gpio_trigger_mux #(
    parameter PINS = `GPIO_PINS,
    parameter CH   = `TX_CHANNELS,
    parameter NSRC = `SRC_COUNT
) (
    // clock, reset, enable
    input  wire                aclk,
    input  wire                aresetn,
    input  wire                clk_en,
    // axi4-lite write
    input  wire [7:0]          s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output reg                 s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output reg                 s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    // axi4-lite read
    input  wire [7:0]          s_axi_araddr,
    input  wire                s_axi_arvalid,
    output reg                 s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    // pins
    input  wire [PINS-1:0]     gpio_in,
    output reg  [PINS-1:0]     gpio_out,
    output reg  [PINS-1:0]     gpio_oe,
    // internal status sources for the control-out mux
    input  wire [NSRC-1:0]     status_src,
    // stream processor triggers
    output reg  [PINS-1:0]     stream_rise_trig,
    output reg  [PINS-1:0]     stream_fall_trig,
    // observation_receiver mapping to embedded processor
    output reg  [PINS-1:0]     map_value,
    output reg                 map_update,
    // applied tx attenuation, channel i in bits [i*10 +: 10]
    output reg  [CH*`ATTEN_BITS-1:0] tx_atten
);

localparam AB = `ATTEN_BITS;

// ----------------------------------------------------------------
// pin synchroniser
// ----------------------------------------------------------------
wire [PINS-1:0] level;
wire [PINS-1:0] rise;
wire [PINS-1:0] fall;

pin_edge_sync #(.WIDTH(PINS)) u_sync (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clk_en     (clk_en),
    .pin_in     (gpio_in),
    .level      (level),
    .rise_pulse (rise),
    .fall_pulse (fall)
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [PINS-1:0]       pin_dir;
reg [PINS-1:0]       rise_en;
reg [PINS-1:0]       fall_en;
reg [PINS-1:0]       stream_status;
reg [2*CH-1:0]       tx_mode;
reg [`GPIO_PIN_BITS*CH-1:0] tx_pin;
reg [CH*AB-1:0]      atten_zero;
reg [CH*AB-1:0]      atten_one;
reg [CH-1:0]         pend;
reg [PINS-1:0]       map_mask;
reg [`SRC_BITS*PINS-1:0] out_sel;

// out-of-range pin numbers select nothing rather than alias
function pin_bit;
    input [PINS-1:0]           vec;
    input [`GPIO_PIN_BITS-1:0] idx;
    begin
        pin_bit = (idx < PINS) ? vec[idx] : 1'b0;
    end
endfunction

// holes between register blocks answer with an error on both channels
function word_mapped;
    input [5:0] word;
    word_mapped = (word <= `REG_MAP_VALUE) || (word >= `REG_OUT_SEL_BASE && word < `REG_OUT_SEL_BASE + PINS);
endfunction

// ----------------------------------------------------------------
// axi4-lite slave
// ----------------------------------------------------------------
reg [5:0]  aw_word;
reg        aw_held;
reg [31:0] w_data;
reg        w_held;
wire       do_write = aw_held && w_held && !s_axi_bvalid;
wire [2:0] cmd_ch   = w_data[`CMD_CH_LSB +: 3];
wire       cmd_slot = w_data[`CMD_SLOT_BIT];
reg [31:0] next_rdata;
reg        rd_hit;

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `AXI_OKAY;
        aw_held       <= 1'b0;
        w_held        <= 1'b0;
        aw_word       <= 6'h00;
        w_data        <= 32'h00000000;
    end else if (clk_en) begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_word       <= s_axi_awaddr[7:2];
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data       <= s_axi_wdata;
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= word_mapped(aw_word) ? `AXI_OKAY : `AXI_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
    end
end

always @* begin
    rd_hit     = word_mapped(s_axi_araddr[7:2]);
    next_rdata = 32'h00000000;
    case (s_axi_araddr[7:2])
        `REG_PIN_DIR:       next_rdata[PINS-1:0] = pin_dir;
        `REG_RISE_EN:       next_rdata[PINS-1:0] = rise_en;
        `REG_FALL_EN:       next_rdata[PINS-1:0] = fall_en;
        `REG_PIN_LEVEL:     next_rdata[PINS-1:0] = level;
        `REG_STREAM_STATUS: next_rdata[PINS-1:0] = stream_status;
        `REG_TX_MODE:       next_rdata[2*CH-1:0] = tx_mode;
        `REG_TX_PIN_LO:     next_rdata[19:0] = tx_pin[19:0];
        `REG_TX_PIN_HI:     next_rdata[19:0] = tx_pin[39:20];
        `REG_ATTEN_PEND:    next_rdata[CH-1:0] = pend;
        `REG_MAP_MASK:      next_rdata[PINS-1:0] = map_mask;
        `REG_MAP_VALUE:     next_rdata[PINS-1:0] = map_value;
        default: begin
            if (s_axi_araddr[7:2] >= `REG_OUT_SEL_BASE && s_axi_araddr[7:2] < `REG_OUT_SEL_BASE + PINS)
                next_rdata[`SRC_BITS-1:0] = out_sel[(s_axi_araddr[7:2] - `REG_OUT_SEL_BASE)*`SRC_BITS +: `SRC_BITS];
        end
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `AXI_OKAY;
    end else if (clk_en) begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
            s_axi_rvalid  <= 1'b1;
            s_axi_arready <= 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// configuration and tx attenuation
// ----------------------------------------------------------------
// each process owns its own loop variable
integer i, rel_i, pin_i;
reg [CH-1:0] release_now;

always @* begin
    for (rel_i = 0; rel_i < CH; rel_i = rel_i + 1)
        release_now[rel_i] = (tx_mode[2*rel_i +: 2] == `MODE_LATCH)
                           && pin_bit(rise, tx_pin[rel_i*`GPIO_PIN_BITS +: `GPIO_PIN_BITS]);
end

always @(posedge aclk) begin
    if (!aresetn) begin
        pin_dir    <= {PINS{1'b0}};
        rise_en    <= {PINS{1'b0}};
        fall_en    <= {PINS{1'b0}};
        tx_mode    <= {2*CH{1'b0}};
        tx_pin     <= {`GPIO_PIN_BITS*CH{1'b0}};
        atten_zero <= {CH*AB{1'b0}};
        atten_one  <= {CH*AB{1'b0}};
        pend       <= {CH{1'b0}};
        map_mask   <= {PINS{1'b0}};
        out_sel    <= {`SRC_BITS*PINS{1'b0}};
        tx_atten   <= {CH*AB{1'b0}};
    end else if (clk_en) begin
        // pending flags clear on release; a new command in the same cycle wins
        pend <= pend & ~release_now;
        if (do_write) begin
            case (aw_word)
                `REG_PIN_DIR:    pin_dir  <= w_data[PINS-1:0];
                `REG_RISE_EN:    rise_en  <= w_data[PINS-1:0];
                `REG_FALL_EN:    fall_en  <= w_data[PINS-1:0];
                `REG_TX_MODE:    tx_mode  <= w_data[2*CH-1:0];
                `REG_TX_PIN_LO:  tx_pin[19:0]  <= w_data[19:0];
                `REG_TX_PIN_HI:  tx_pin[39:20] <= w_data[19:0];
                `REG_MAP_MASK:   map_mask <= w_data[PINS-1:0];
                `REG_ATTEN_CMD: begin
                    if (cmd_slot)
                        atten_one[cmd_ch*AB +: AB]  <= w_data[AB-1:0];
                    else
                        atten_zero[cmd_ch*AB +: AB] <= w_data[AB-1:0];
                    if (tx_mode[2*cmd_ch +: 2] == `MODE_LATCH && !cmd_slot)
                        pend[cmd_ch] <= 1'b1;
                end
                default: begin
                    if (aw_word >= `REG_OUT_SEL_BASE && aw_word < `REG_OUT_SEL_BASE + PINS)
                        out_sel[(aw_word - `REG_OUT_SEL_BASE)*`SRC_BITS +: `SRC_BITS] <= w_data[`SRC_BITS-1:0];
                end
            endcase
        end
        for (i = 0; i < CH; i = i + 1) begin
            case (tx_mode[2*i +: 2])
                `MODE_LATCH: begin
                    if (pend[i] && release_now[i])
                        tx_atten[i*AB +: AB] <= atten_zero[i*AB +: AB];
                end
                `MODE_TWO_STATE: begin
                    // all channels read the same shared level vector
                    if (pin_bit(level, tx_pin[i*`GPIO_PIN_BITS +: `GPIO_PIN_BITS]))
                        tx_atten[i*AB +: AB] <= atten_one[i*AB +: AB];
                    else
                        tx_atten[i*AB +: AB] <= atten_zero[i*AB +: AB];
                end
                default: tx_atten[i*AB +: AB] <= atten_zero[i*AB +: AB];
            endcase
        end
    end
end

// ----------------------------------------------------------------
// stream triggers, mapping and control-out mux
// ----------------------------------------------------------------
wire [PINS-1:0] in_pins = ~pin_dir;
wire [PINS-1:0] map_now = level & map_mask & in_pins;

always @(posedge aclk) begin
    if (!aresetn) begin
        stream_rise_trig <= {PINS{1'b0}};
        stream_fall_trig <= {PINS{1'b0}};
        stream_status    <= {PINS{1'b0}};
        map_value        <= {PINS{1'b0}};
        map_update       <= 1'b0;
        gpio_out         <= {PINS{1'b0}};
        gpio_oe          <= {PINS{1'b0}};
    end else if (clk_en) begin
        stream_rise_trig <= rise & rise_en & in_pins;
        stream_fall_trig <= fall & fall_en & in_pins;
        // sticky record of fired triggers; a read-back write of ones clears, new edges win
        stream_status    <= (stream_status
                            & ~((do_write && aw_word == `REG_STREAM_STATUS) ? w_data[PINS-1:0] : {PINS{1'b0}}))
                            | (((rise & rise_en) | (fall & fall_en)) & in_pins);
        map_value        <= map_now;
        map_update       <= (map_now != map_value);
        gpio_oe          <= pin_dir;
        for (pin_i = 0; pin_i < PINS; pin_i = pin_i + 1)
            gpio_out[pin_i] <= pin_dir[pin_i] & status_src[out_sel[pin_i*`SRC_BITS +: `SRC_BITS]];
    end
end

endmodule

// >>> bench/gpio_trigger_mux_props.sv
// assertion checker for the pin trigger and output mux block
`timescale 1ns/1ps
module gpio_trigger_mux_props #(
    parameter PINS = 24,
    parameter CH   = 8
) (
    // clock and reset
    input wire              aclk,
    input wire              aresetn,
    // pins
    input wire [PINS-1:0]   gpio_in,
    input wire [PINS-1:0]   gpio_out,
    input wire [PINS-1:0]   gpio_oe,
    // triggers, mapping, attenuation
    input wire [PINS-1:0]   stream_rise_trig,
    input wire [PINS-1:0]   stream_fall_trig,
    input wire [PINS-1:0]   map_value,
    input wire              map_update,
    input wire [CH*10-1:0]  tx_atten
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    trig_pulse_a: assert property ((stream_rise_trig & $past(stream_rise_trig)) == 0 &&
        (stream_fall_trig & $past(stream_fall_trig)) == 0) else $error("trigger wider than one cycle");
    edge_excl_a: assert property ((stream_rise_trig & stream_fall_trig) == 0)
        else $error("rise and fall trigger together");
    // a trigger stands four edges after the pin change that caused it
    rise_cause_a: assert property ((stream_rise_trig & ~($past(gpio_in, 4) & ~$past(gpio_in, 5))) == 0)
        else $error("rise trigger without pin rise");
    fall_cause_a: assert property ((stream_fall_trig & ~(~$past(gpio_in, 4) & $past(gpio_in, 5))) == 0)
        else $error("fall trigger without pin fall");
    trig_dir_a: assert property (((stream_rise_trig | stream_fall_trig) & gpio_oe) == 0)
        else $error("trigger on an output pin");
    out_dir_a: assert property ((gpio_out & ~gpio_oe) == 0)
        else $error("mux drives an input pin");
    map_upd_a: assert property ($changed(map_value) |-> ##[0:1] map_update)
        else $error("mapping change not forwarded");
    map_input_a: assert property ((map_value & gpio_oe) == 0)
        else $error("mapping taken from an output pin");
    cover property (stream_rise_trig != 0);
    cover property (stream_fall_trig != 0);
    cover property (map_update);
    cover property ($changed(tx_atten));
endmodule
bind gpio_trigger_mux gpio_trigger_mux_props #(.PINS(PINS), .CH(CH)) props_i (
    .aclk(aclk), .aresetn(aresetn), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .stream_rise_trig(stream_rise_trig), .stream_fall_trig(stream_fall_trig),
    .map_value(map_value), .map_update(map_update), .tx_atten(tx_atten));

// >>> bench/ext_pin_logic.sv
// external control logic model driving the pin inputs
`timescale 1ns/1ps
module ext_pin_logic (
    // clock
    input  wire        aclk,
    // levels requested by the scenario
    input  wire [23:0] want,
    // pad side
    input  wire [23:0] gpio_out,
    input  wire [23:0] gpio_oe,
    output wire [23:0] gpio_in
);
    reg [23:0] drive;
    // levels move just after an edge and hold until the next request
    always @(posedge aclk) begin
        drive <= want;
    end
    // a pin the device drives shows the device's own value on the wire
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & drive);
endmodule

// >>> bench/tb_digital_gpio_trigger_and_out_mux.sv
// self-checking bench for the pin trigger and output mux block
`timescale 1ns/1ps
module tb_digital_gpio_trigger_and_out_mux;
    reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    reg  [7:0]  awaddr, araddr, ad;
    reg  [31:0] wdata, status_src, r32;
    reg  [23:0] want, v, pv, rs, fs, st;
    reg  [4:0]  sel [0:7];
    reg  [9:0]  av [0:5];
    wire        awready, wready, bvalid, arready, rvalid, mapu;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [23:0] gpio_in, gpio_out, gpio_oe, rtrig, ftrig, mapv;
    wire [79:0] atten;
    integer     errors, total_checks, seed, k, mu;

    gpio_trigger_mux dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .status_src(status_src), .stream_rise_trig(rtrig), .stream_fall_trig(ftrig),
        .map_value(mapv), .map_update(mapu), .tx_atten(atten));
    ext_pin_logic far_end (.aclk(aclk), .want(want), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // ----------------------------------------
    // tasks and expectations
    // ----------------------------------------
    task chk(input [79:0] s, input [79:0] e); begin
        total_checks = total_checks + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    end endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er); begin
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk(bresp, er);
        bready <= 1'b0;
    end endtask
    task rd(input [7:0] a, input [1:0] er); begin
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        r32 = rdata;
        chk(rresp, er);
        rready <= 1'b0;
    end endtask
    // sync plus registered edge detect stays well inside ten cycles
    task pin_set(input [23:0] p); begin
        @(posedge aclk);
        want <= p;
        rs = 24'h0;
        fs = 24'h0;
        mu = 0;
        repeat (10) begin
            @(posedge aclk);
            rs = rs | rtrig;
            fs = fs | ftrig;
            mu = mu + mapu;
        end
    end endtask
    function [7:0] mux_exp(input [31:0] s);
        integer j;
        begin
            for (j = 0; j < 8; j = j + 1) mux_exp[j] = s[sel[j]];
        end
    endfunction
    function [31:0] cmd(input [9:0] val, input [2:0] ch, input slot);
        cmd = {11'h0, slot, 1'b0, ch, 6'h0, val};
    endfunction
    task summarize; begin
        $display("checks=%0d mismatches=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    end endtask
    initial begin
        #100000;
        errors = errors + 1;
        summarize;
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {seed, errors, total_checks} = {32'd48, 64'd0};
        {aresetn, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = 0;
        {status_src, want} = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 2'h0); chk(r32, 0);
        rd(8'h24, 2'h0); chk(r32, 0);
        rd(8'h34, 2'h2);
        wr(8'h38, 32'h1, 2'h2);
        $display("reset and bus test done");
        wr(8'h00, 32'h00FF0000, 2'h0);
        for (k = 0; k < 8; k = k + 1) begin
            r32 = $random(seed);
            sel[k] = (k == 0) ? 5'h1F : r32[4:0];
            ad = 8'h80 + {k[5:0], 2'h0};
            wr(ad, {27'h0, sel[k]}, 2'h0);
        end
        repeat (3) begin
            r32 = $random(seed);
            status_src <= r32;
            repeat (4) @(posedge aclk);
            chk(gpio_out, {mux_exp(r32), 16'h0});
            chk(gpio_oe, 24'hFF0000);
        end
        $display("output mux test done");
        wr(8'h04, 32'hFFFFFF, 2'h0);
        wr(8'h08, 32'hFFFFFF, 2'h0);
        wr(8'h2C, 32'h00F0F0, 2'h0);
        pv = 24'h0;
        st = 24'h0;
        for (k = 0; k < 6; k = k + 1) begin
            r32 = $random(seed);
            v = (k == 1) ? 24'h00FFFF : (k == 2) ? 24'h0 : {8'h0, r32[15:0]};
            pin_set(v);
            chk(rs, v & ~pv);
            chk(fs, pv & ~v);
            chk(mapv, v & 24'h00F0F0);
            rd(8'h0C, 2'h0); chk(r32[15:0], v[15:0]);
            chk(mu, ((v ^ pv) & 24'h00F0F0) != 24'h0);
            st = st | (v ^ pv);
            pv = v;
        end
        rd(8'h10, 2'h0); chk(r32[23:0], st);
        wr(8'h10, {8'h0, st}, 2'h0);
        rd(8'h10, 2'h0); chk(r32, 0);
        $display("edge trigger test done");
        pin_set(24'h0);
        for (k = 0; k < 6; k = k + 1) begin
            r32 = $random(seed);
            av[k] = (k == 0) ? 10'h3FF : r32[9:0];
        end
        wr(8'h14, 32'h5, 2'h0);
        wr(8'h18, 32'h63, 2'h0);
        wr(8'h20, cmd(av[0], 3'h0, 1'b0), 2'h0);
        wr(8'h20, cmd(av[1], 3'h1, 1'b0), 2'h0);
        rd(8'h28, 2'h0); chk(r32, 32'h3);
        pin_set(24'h0); chk(atten[19:0], 20'h0);
        pin_set(24'h8); chk(atten[19:0], {av[1], av[0]});
        rd(8'h28, 2'h0); chk(r32, 0);
        $display("latch test done");
        wr(8'h14, 32'hA5, 2'h0);
        wr(8'h18, 32'h29463, 2'h0);
        for (k = 0; k < 4; k = k + 1) wr(8'h20, cmd(av[k+2], k[1] ? 3'h3 : 3'h2, k[0]), 2'h0);
        for (k = 0; k < 3; k = k + 1) begin
            pin_set((k == 1) ? 24'h28 : 24'h8);
            chk(atten[39:20], (k == 1) ? {av[5], av[3]} : {av[4], av[2]});
        end
        $display("two-state test done");
        summarize;
    end
endmodule
